// *** mux_step_pkg.sv ***
// package for the sequencer step eight/nine configuration bank
package mux_step_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  STEP_EIGHT_IDX   = 8'hD8;
  localparam logic [7:0]  STEP_NINE_IDX    = 8'hD9;
  localparam logic [11:0] STEP_EIGHT_ADDR  = 12'h360;
  localparam logic [11:0] STEP_NINE_ADDR   = 12'h364;
  // field positions
  localparam int EN_BIT   = 15;
  localparam int GAIN_HI  = 14;
  localparam int GAIN_LO  = 13;
  localparam int NEG_BIT  = 4;
  localparam int POS_HI   = 3;
  localparam int POS_LO   = 0;
  // reset values
  localparam logic [15:0] STEP_EIGHT_RST   = 16'h0008;
  localparam logic [15:0] STEP_NINE_RST    = 16'h0009;
  // positive input codes of interest
  localparam logic [3:0]  POS_TEMP_SENSOR  = 4'h8;
  localparam logic [3:0]  POS_GROUND_SHORT = 4'h9;
  localparam logic [3:0]  POS_AUTO_FIRST   = 4'h8;
  // analog select outputs for the active step
  typedef struct packed {
    logic       valid;
    logic [2:0] gain;
    logic [3:0] pos_sel;
    logic       neg_ext;
    logic       ext_disc;
  } mux_sel_t;
endpackage

// *** mux_sequencer_step_config.sv ***
// step eight and nine configuration registers with apb slave and step select
`timescale 1ns/1ps
module mux_sequencer_step_config (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 step_request,
  input  wire logic                 step_select_nine,
  output mux_step_pkg::mux_sel_t    step_sel,
  output logic                      step_eight_enable,
  output logic                      step_nine_enable
);

  // only writable bits are held; reserved bits have no storage
  logic [1:0]  step_eight_gain_code_r;
  logic        step_eight_neg_select_r;
  logic [3:0]  step_eight_pos_select_r;
  logic [1:0]  step_nine_gain_code_r;
  logic        step_nine_neg_select_r;
  logic [3:0]  step_nine_pos_select_r;
  logic [31:0] prdata_nxt;
  mux_step_pkg::mux_sel_t step_sel_nxt;

  // gain code to multiplier, both high codes give four
  function automatic logic [2:0] gain_of(input logic [1:0] code);
    unique case (code)
      2'h0:    gain_of = 3'h1;
      2'h1:    gain_of = 3'h2;
      default: gain_of = 3'h4;
    endcase
  endfunction

  // internal sources own the negative input
  function automatic logic auto_neg(input logic [3:0] pos);
    auto_neg = (pos >= mux_step_pkg::POS_AUTO_FIRST);
  endfunction

  // pack a register image; reserved bits stay zero
  function automatic logic [15:0] pack_step(input logic en, input logic [1:0] g,
                                            input logic n, input logic [3:0] p);
    pack_step = {en, g, 8'h00, n, p};
  endfunction

  // decode
  wire access_ph   = psel & penable;
  wire hit_eight   = (paddr == mux_step_pkg::STEP_EIGHT_ADDR);
  wire hit_nine    = (paddr == mux_step_pkg::STEP_NINE_ADDR);
  wire mapped      = hit_eight | hit_nine;
  wire wr_lo       = access_ph & pwrite & pstrb[0];
  wire wr_hi       = access_ph & pwrite & pstrb[1];
  wire [15:0] img_eight = pack_step(step_eight_enable, step_eight_gain_code_r,
                                    step_eight_neg_select_r, step_eight_pos_select_r);
  wire [15:0] img_nine  = pack_step(step_nine_enable, step_nine_gain_code_r,
                                    step_nine_neg_select_r, step_nine_pos_select_r);

  // read mux; unmapped reads return zero with an error
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (hit_eight) begin
      prdata_nxt = {16'h0000, img_eight};
    end else if (hit_nine) begin
      prdata_nxt = {16'h0000, img_nine};
    end
  end

  // zero wait state slave: pready registered high in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? prdata_nxt : 32'h0000_0000;
    end
  end

  // write takes effect at the edge where pready is seen high
  wire wr_go = pready & access_ph;

  // step eight storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_eight_enable       <= mux_step_pkg::STEP_EIGHT_RST[mux_step_pkg::EN_BIT];
      step_eight_gain_code_r  <= mux_step_pkg::STEP_EIGHT_RST[14:13];
      step_eight_neg_select_r <= mux_step_pkg::STEP_EIGHT_RST[4];
      step_eight_pos_select_r <= mux_step_pkg::STEP_EIGHT_RST[3:0];
    end else if (wr_go && hit_eight) begin
      if (wr_lo) begin
        step_eight_neg_select_r <= pwdata[mux_step_pkg::NEG_BIT];
        step_eight_pos_select_r <= pwdata[mux_step_pkg::POS_HI:mux_step_pkg::POS_LO];
      end
      if (wr_hi) begin
        step_eight_enable      <= pwdata[mux_step_pkg::EN_BIT];
        step_eight_gain_code_r <= pwdata[mux_step_pkg::GAIN_HI:mux_step_pkg::GAIN_LO];
      end
    end
  end

  // step nine storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_nine_enable       <= mux_step_pkg::STEP_NINE_RST[15];
      step_nine_gain_code_r  <= mux_step_pkg::STEP_NINE_RST[14:13];
      step_nine_neg_select_r <= mux_step_pkg::STEP_NINE_RST[4];
      step_nine_pos_select_r <= mux_step_pkg::STEP_NINE_RST[3:0];
    end else if (wr_go && hit_nine) begin
      if (wr_lo) begin
        step_nine_neg_select_r <= pwdata[mux_step_pkg::NEG_BIT];
        step_nine_pos_select_r <= pwdata[mux_step_pkg::POS_HI:mux_step_pkg::POS_LO];
      end
      if (wr_hi) begin
        step_nine_enable      <= pwdata[mux_step_pkg::EN_BIT];
        step_nine_gain_code_r <= pwdata[mux_step_pkg::GAIN_HI:mux_step_pkg::GAIN_LO];
      end
    end
  end

  // step select: a disabled step yields no valid selection, so the engine skips it
  wire        pick_en  = step_select_nine ? step_nine_enable : step_eight_enable;
  wire [1:0]  pick_g   = step_select_nine ? step_nine_gain_code_r : step_eight_gain_code_r;
  wire        pick_n   = step_select_nine ? step_nine_neg_select_r : step_eight_neg_select_r;
  wire [3:0]  pick_p   = step_select_nine ? step_nine_pos_select_r : step_eight_pos_select_r;

  always_comb begin
    step_sel_nxt.valid    = step_request & pick_en;
    step_sel_nxt.gain     = gain_of(pick_g);
    step_sel_nxt.pos_sel  = pick_p;
    step_sel_nxt.neg_ext  = pick_n & ~auto_neg(pick_p);
    step_sel_nxt.ext_disc = (pick_p == mux_step_pkg::POS_GROUND_SHORT);
  end

  // registered so the analog switches see glitch-free controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_sel <= '0;
    end else begin
      step_sel <= step_sel_nxt;
    end
  end

  // checks
  property p_eight_reset_code;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> step_eight_pos_select_r == mux_step_pkg::POS_TEMP_SENSOR;
  endproperty
  a_eight_reset_code: assert property (p_eight_reset_code)
    else $error("step eight reset code");

  property p_enable_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && hit_eight && wr_hi) |=> step_eight_enable == $past(pwdata[15]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not written");

  property p_gain_map;
    @(posedge pclk) disable iff (!presetn)
    step_sel_nxt.gain == ((pick_g == 2'h0) ? 3'h1 : (pick_g == 2'h1) ? 3'h2 : 3'h4);
  endproperty
  a_gain_map: assert property (p_gain_map) else $error("gain map wrong");

  property p_neg_ignored;
    @(posedge pclk) disable iff (!presetn)
    (pick_p[3]) |=> !step_sel.neg_ext;
  endproperty
  a_neg_ignored: assert property (p_neg_ignored) else $error("neg select not ignored");

  property p_neg_follows;
    @(posedge pclk) disable iff (!presetn)
    (!pick_p[3]) |=> step_sel.neg_ext == $past(pick_n);
  endproperty
  a_neg_follows: assert property (p_neg_follows) else $error("neg select lost");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
    pready |-> prdata[12:5] == 8'h00 && prdata[31:16] == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits nonzero");

  property p_skip_disabled;
    @(posedge pclk) disable iff (!presetn)
    (step_request && !pick_en) |=> !step_sel.valid;
  endproperty
  a_skip_disabled: assert property (p_skip_disabled) else $error("disabled step used");

  property p_short_disc;
    @(posedge pclk) disable iff (!presetn)
    (pick_p == 4'h9) |=> step_sel.ext_disc ##0 step_sel.pos_sel == 4'h9;
  endproperty
  a_short_disc: assert property (p_short_disc) else $error("ground short wrong");

  property p_nine_read;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_nine) |=> prdata[15:0] == $past(img_nine);
  endproperty
  a_nine_read: assert property (p_nine_read) else $error("step nine read wrong");

  // whole register images right after reset, not only the code field
  property p_eight_reset_image;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> img_eight == mux_step_pkg::STEP_EIGHT_RST;
  endproperty
  a_eight_reset_image: assert property (p_eight_reset_image)
    else $error("step eight reset image wrong");

  property p_nine_reset_image;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> img_nine == mux_step_pkg::STEP_NINE_RST;
  endproperty
  a_nine_reset_image: assert property (p_nine_reset_image)
    else $error("step nine reset image wrong");

  // field writes land one edge after the accepted access
  property p_nine_enable_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && hit_nine && wr_hi) |=> step_nine_enable == $past(pwdata[mux_step_pkg::EN_BIT]);
  endproperty
  a_nine_enable_write: assert property (p_nine_enable_write)
    else $error("step nine enable not written");

  property p_pos_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && hit_eight && wr_lo) |=> step_eight_pos_select_r == $past(pwdata[3:0]);
  endproperty
  a_pos_write: assert property (p_pos_write)
    else $error("step eight positive code not written");

  // gain only moves on a write of the upper lane
  property p_gain_hold;
    @(posedge pclk) disable iff (!presetn)
    !(wr_go && wr_hi) |=> $stable(step_eight_gain_code_r) && $stable(step_nine_gain_code_r);
  endproperty
  a_gain_hold: assert property (p_gain_hold)
    else $error("gain code changed without write");

  // registered gain seen by the converter, not just the function result
  property p_gain_double;
    @(posedge pclk) disable iff (!presetn)
    (pick_g == 2'h1) |=> step_sel.gain == 3'h2;
  endproperty
  a_gain_double: assert property (p_gain_double)
    else $error("gain two not applied");

  property p_gain_quad;
    @(posedge pclk) disable iff (!presetn)
    pick_g[1] |=> step_sel.gain == 3'h4;
  endproperty
  a_gain_quad: assert property (p_gain_quad)
    else $error("gain four not applied");

  // external codes pass through and never disconnect the pins
  property p_ext_pos_pass;
    @(posedge pclk) disable iff (!presetn)
    !pick_p[3] |=> step_sel.pos_sel == $past(pick_p) && !step_sel.ext_disc;
  endproperty
  a_ext_pos_pass: assert property (p_ext_pos_pass)
    else $error("external input code lost");

  property p_temp_route;
    @(posedge pclk) disable iff (!presetn)
    (pick_p == mux_step_pkg::POS_TEMP_SENSOR) |=>
      step_sel.pos_sel == mux_step_pkg::POS_TEMP_SENSOR && !step_sel.ext_disc;
  endproperty
  a_temp_route: assert property (p_temp_route)
    else $error("temperature sensor route wrong");

  property p_internal_src;
    @(posedge pclk) disable iff (!presetn)
    (pick_p > 4'h9) |=>
      step_sel.pos_sel == $past(pick_p) && !step_sel.neg_ext && !step_sel.ext_disc;
  endproperty
  a_internal_src: assert property (p_internal_src)
    else $error("internal source selection wrong");

  property p_eight_read;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_eight) |=> prdata[15:0] == $past(img_eight);
  endproperty
  a_eight_read: assert property (p_eight_read)
    else $error("step eight read wrong");

  // a write outside the bank must leave both registers alone
  property p_unmapped_quiet;
    @(posedge pclk) disable iff (!presetn)
    (wr_go && !mapped) |=> $stable(img_eight) && $stable(img_nine);
  endproperty
  a_unmapped_quiet: assert property (p_unmapped_quiet)
    else $error("unmapped write changed a register");

  property p_valid_enabled;
    @(posedge pclk) disable iff (!presetn)
    (step_request && pick_en) |=> step_sel.valid;
  endproperty
  a_valid_enabled: assert property (p_valid_enabled)
    else $error("enabled step not applied");

  c_write_eight: cover property (@(posedge pclk) disable iff (!presetn) wr_go && hit_eight);
  c_read_nine: cover property (@(posedge pclk) disable iff (!presetn) pready && hit_nine && !pwrite);
  c_valid_step: cover property (@(posedge pclk) disable iff (!presetn) step_sel.valid);
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_auto_neg: cover property (@(posedge pclk) disable iff (!presetn) step_sel.valid && step_sel.pos_sel[3]);

endmodule // mux_sequencer_step_config

// *** test_mux_sequencer_step_config.sv ***
// self-checking bench for the step eight/nine configuration bank
`timescale 1ns/1ps
module test_mux_sequencer_step_config;
  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [11:0]            paddr;
  logic [31:0]            pwdata;
  logic [3:0]             pstrb;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   step_request;
  logic                   step_select_nine;
  mux_step_pkg::mux_sel_t step_sel;
  logic                   step_eight_enable;
  logic                   step_nine_enable;
  int                     errors;
  int                     n_compared;
  int unsigned            seed;
  logic [31:0]            model [2];
  logic [31:0]            rd;
  logic                   err;

  mux_sequencer_step_config i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .step_request(step_request), .step_select_nine(step_select_nine),
    .step_sel(step_sel), .step_eight_enable(step_eight_enable),
    .step_nine_enable(step_nine_enable));

  // free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high, no fixed wait assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      errors++;
      $display("Error at %0t: no pready", $time);
      wrap_up();
    end
  endtask

  // held four cycles; the model returns to the documented reset values
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    model[0] = 32'h00000008;
    model[1] = 32'h00000009;
  endtask

  task automatic check_regs();
    apb(1'b0, mux_step_pkg::STEP_EIGHT_ADDR, 32'h0, 4'h0);
    chk(rd, model[0], "step eight read");
    apb(1'b0, mux_step_pkg::STEP_NINE_ADDR, 32'h0, 4'h0);
    chk(rd, model[1], "step nine read");
    chk({step_eight_enable, step_nine_enable}, {model[0][15], model[1][15]}, "enables");
  endtask

  // selection output one cycle after the request; detail only matters for a valid step
  task automatic step_chk(input logic req, input logic nine);
    mux_step_pkg::mux_sel_t e;
    logic [31:0]            v;
    v = model[nine];
    step_request <= req;
    step_select_nine <= nine;
    repeat (2) @(posedge pclk);
    e.valid = req & v[15];
    e.gain = (v[14:13] == 2'h0) ? 3'h1 : (v[14:13] == 2'h1) ? 3'h2 : 3'h4;
    e.pos_sel = v[3:0];
    e.neg_ext = v[3] ? 1'b0 : v[4];
    e.ext_disc = (v[3:0] == 4'h9);
    chk({31'h0, step_sel.valid}, {31'h0, e.valid}, "step valid");
    if (e.valid) begin
      chk({22'h0, step_sel}, {22'h0, e}, "step select");
    end
  endtask

  initial begin
    logic [31:0] d;
    int          k;
    seed = 995;
    errors = 0;
    n_compared = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {step_request, step_select_nine} = 2'h0;
    do_reset();
    check_regs();
    // every positive code with enable, negative select set and cycling gain
    for (int c = 0; c < 16; c++) begin
      d = {16'h0, 1'b1, c[1:0], 8'h0, 1'b1, c[3:0]};
      apb(1'b1, mux_step_pkg::STEP_EIGHT_ADDR, d, 4'hF);
      model[0] = d & 32'h0000E01F;
      step_chk(1'b1, 1'b0);
    end
    // random writes, strobes and addresses, one in three unmapped
    for (int n = 0; n < 40; n++) begin
      k = int'(rnd() % 3);
      d = rnd();
      apb(1'b1, (k == 2) ? 12'h368 : (k == 1) ? mux_step_pkg::STEP_NINE_ADDR :
          mux_step_pkg::STEP_EIGHT_ADDR, d, d[19:16]);
      chk({31'h0, err}, (k == 2) ? 32'h1 : 32'h0, "slave error");
      if (k < 2 && d[16]) model[k] = (model[k] & 32'hFFE0) | (d & 32'h001F);
      if (k < 2 && d[17]) model[k] = (model[k] & 32'h1FFF) | (d & 32'hE000);
      check_regs();
      d = rnd();
      step_chk(d[0], d[1]);
    end
    apb(1'b0, 12'h368, 32'h0, 4'h0);
    chk({31'h0, err}, 32'h1, "unmapped read error");
    chk(rd, 32'h0, "unmapped read data");
    do_reset();
    check_regs();
    wrap_up();
  end
endmodule // test_mux_sequencer_step_config
